// ---- core/acr_pkg.sv ----
// Package with register map, field layout and timing constants of the converter control block.
package acr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_PRESCALER = 8'hf2;
    localparam logic [7:0] ADDR_CONTROL = 8'hf3;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hf4;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hf5;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hf6;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int BIT_HALT = 6;
    localparam int BIT_POWER = 5;
    localparam int BIT_DONE = 4;
    localparam int BIT_START = 3;
    localparam int CH_MSB = 2;
    localparam int PRS_MSB = 4;

    // ****************************************
    // Timing
    // ****************************************
    localparam logic [7:0] DIV_X1_MULT = 8'h04;
    localparam logic [7:0] DIV_X2_MULT = 8'h02;
    localparam logic [7:0] DIV_X1_ZERO = 8'h80;
    localparam logic [7:0] DIV_X2_ZERO = 8'h40;
    localparam logic [3:0] CONV_PERIODS = 4'hb;
    localparam logic [3:0] BITS_START = 4'h9;

    typedef enum logic [2:0] {
        ACR_IDLE = 3'b001,
        ACR_SAMPLE = 3'b010,
        ACR_CONVERT = 3'b100
    } acr_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acr_bus_s;

endpackage

// ---- core/acr_adc_control.sv ----
// Converter control registers, clock prescaler and successive conversion sequencer.
//
// Operation
// - When the precision halt bit is set, the CPU is held halted for the whole conversion.
// - The power-on bit powers the converter up when set and puts it in standby when clear.
// - Writing one to the start bit, with the power bit set in the same write, launches one conversion on the selected channel.
// - Hardware clears the start bit when the conversion completes.
// - Control bits 2-0 select the channel sampled by the next conversion.
// - In single-speed mode the converter clock is osc/(4*prs), or osc/128 for prs zero.
// - In double-speed mode the converter clock is osc/(2*prs), or osc/64 for prs zero.
// - The high result byte holds result bits 9-2 and resets to zero.
// - The low result byte holds result bits 1-0 in positions 1-0 and resets to zero.
// - The channel value n selects analog input n as a plain binary index.
// - Software clears the done flag; with the IRQ enable set a set flag requests an IRQ.
// - A conversion takes 11 converter clocks: one sample and ten bit periods.
`timescale 1ns/1ps

module acr_adc_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire acr_pkg::acr_bus_s bus,
    output logic [7:0] rd_data,
    // Clock mode
    input wire logic double_speed_clocking,
    // Analog front end
    input wire logic cmp_in,
    output logic [7:0] channel_enable,
    output logic [9:0] dac_code,
    output logic sample_hold,
    output logic converter_power_on,
    // System
    output logic cpu_halt,
    output logic irq
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] div_ratio(input logic [4:0] prs, input logic x2);
        logic [7:0] r;
        r = 8'h00;
        if (prs == 5'h00) begin
            r = x2 ? acr_pkg::DIV_X2_ZERO : acr_pkg::DIV_X1_ZERO;
        end else begin
            r = x2 ? 8'({3'h0, prs} * acr_pkg::DIV_X2_MULT)
                   : 8'({3'h0, prs} * acr_pkg::DIV_X1_MULT);
        end
        return r;
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic cmp_meta_q, cmp_sync_q;
    logic [4:0] prs_q, prs_d;
    logic halt_q, halt_d, power_q, power_d, done_q, done_d, start_q, start_d;
    logic [2:0] chan_q, chan_d;
    logic ien_q, ien_d;
    logic [9:0] result_q, result_d, sar_q, sar_d;
    logic [7:0] rd_q, rd_d;
    logic [7:0] div_q, div_d;
    logic tick;
    logic [3:0] bit_q, bit_d;
    acr_pkg::acr_state_e state_q, state_d;
    logic wr_ctl;
    logic finish;
    logic [7:0] chan_en_q, chan_en_d;
    logic sample_q, sample_d, halt_out_q, halt_out_d, irq_q, irq_d;

    // The comparator is asynchronous to this clock and passes two flops first. At the shortest
    // divide the decision therefore lags the trial code and may be stale.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_in;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ****************************************
    // Prescaler
    // ****************************************
    always_comb begin
        tick = 1'b0;
        div_d = div_q + 8'h01;
        if (state_q == acr_pkg::ACR_IDLE) begin
            div_d = 8'h00;
        end else if (div_q >= div_ratio(prs_q, double_speed_clocking) - 8'h01) begin
            div_d = 8'h00;
            tick = 1'b1;
        end
    end

    // ****************************************
    // Registers and sequencer
    // ****************************************
    assign wr_ctl = bus.wr && bus.addr == acr_pkg::ADDR_CONTROL;

    always_comb begin
        prs_d = prs_q;
        halt_d = halt_q;
        power_d = power_q;
        done_d = done_q;
        start_d = start_q;
        chan_d = chan_q;
        ien_d = ien_q;
        result_d = result_q;
        sar_d = sar_q;
        bit_d = bit_q;
        state_d = state_q;
        finish = 1'b0;
        if (bus.wr && bus.addr == acr_pkg::ADDR_PRESCALER) begin
            prs_d = bus.wdata[acr_pkg::PRS_MSB:0];
        end
        if (bus.wr && bus.addr == acr_pkg::ADDR_IRQ_ENABLE) begin
            ien_d = bus.wdata[0];
        end
        // A zero at the flag position clears the done flag. A completion in the same cycle is
        // assigned further down and wins, so no finished result goes unflagged.
        if (wr_ctl) begin
            halt_d = bus.wdata[acr_pkg::BIT_HALT];
            power_d = bus.wdata[acr_pkg::BIT_POWER];
            chan_d = bus.wdata[acr_pkg::CH_MSB:0];
            if (!bus.wdata[acr_pkg::BIT_DONE]) begin
                done_d = 1'b0;
            end
        end
        unique case (state_q)
            acr_pkg::ACR_IDLE: begin
                if (wr_ctl && bus.wdata[acr_pkg::BIT_START] && bus.wdata[acr_pkg::BIT_POWER]) begin
                    start_d = 1'b1;
                    sar_d = 10'h000;
                    bit_d = acr_pkg::BITS_START;
                    state_d = acr_pkg::ACR_SAMPLE;
                end
            end
            acr_pkg::ACR_SAMPLE: begin
                if (tick) begin
                    sar_d = 10'h200;
                    state_d = acr_pkg::ACR_CONVERT;
                end
            end
            acr_pkg::ACR_CONVERT: begin
                if (tick) begin
                    if (!cmp_sync_q) begin
                        sar_d[bit_q] = 1'b0;
                    end
                    if (bit_q == 4'h0) begin
                        finish = 1'b1;
                        result_d = cmp_sync_q ? sar_q : (sar_q & ~10'h001);
                        done_d = 1'b1;
                        start_d = 1'b0;
                        state_d = acr_pkg::ACR_IDLE;
                    end else begin
                        sar_d[bit_q - 4'h1] = 1'b1;
                        bit_d = bit_q - 4'h1;
                    end
                end
            end
        endcase
        // Dropping the power bit abandons a running conversion: the busy bit clears and, unless the last
        // bit period ends in the first cycle with power low, the result registers keep their old contents.
        if (!power_q && state_q != acr_pkg::ACR_IDLE) begin
            start_d = 1'b0;
            state_d = acr_pkg::ACR_IDLE;
        end
    end

    always_comb begin
        rd_d = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                acr_pkg::ADDR_PRESCALER: rd_d = {3'h0, prs_q};
                acr_pkg::ADDR_CONTROL: rd_d = {1'b0, halt_q, power_q, done_q, start_q, chan_q};
                acr_pkg::ADDR_RESULT_LOW: rd_d = {6'h00, result_q[1:0]};
                acr_pkg::ADDR_RESULT_HIGH: rd_d = result_q[9:2];
                acr_pkg::ADDR_IRQ_ENABLE: rd_d = {7'h00, ien_q};
                default: rd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prs_q <= 5'h00;
            halt_q <= 1'b0;
            power_q <= 1'b0;
            done_q <= 1'b0;
            start_q <= 1'b0;
            chan_q <= 3'h0;
            ien_q <= 1'b0;
            result_q <= 10'h000;
            sar_q <= 10'h000;
            bit_q <= 4'h0;
            div_q <= 8'h00;
            rd_q <= acr_pkg::RESET_BYTE;
            state_q <= acr_pkg::ACR_IDLE;
        end else begin
            prs_q <= prs_d;
            halt_q <= halt_d;
            power_q <= power_d;
            done_q <= done_d;
            start_q <= start_d;
            chan_q <= chan_d;
            ien_q <= ien_d;
            result_q <= result_d;
            sar_q <= sar_d;
            bit_q <= bit_d;
            div_q <= div_d;
            rd_q <= rd_d;
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Output flops load from the next-state values, so they change on the same edge as the
    // registers that they reflect.
    always_comb begin
        chan_en_d = 8'h01 << chan_d;
        sample_d = state_d == acr_pkg::ACR_SAMPLE;
        halt_out_d = halt_d && start_d;
        irq_d = done_d && ien_d;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_en_q <= 8'h01;
            sample_q <= 1'b0;
            halt_out_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            chan_en_q <= chan_en_d;
            sample_q <= sample_d;
            halt_out_q <= halt_out_d;
            irq_q <= irq_d;
        end
    end

    assign rd_data = rd_q;
    assign channel_enable = chan_en_q;
    assign dac_code = sar_q;
    assign sample_hold = sample_q;
    assign converter_power_on = power_q;
    assign cpu_halt = halt_out_q;
    assign irq = irq_q;

    // ****************************************
    // Checks
    // ****************************************
    AST_HALT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_halt == (halt_q && state_q != acr_pkg::ACR_IDLE)) else $error("halt mismatch");
    AST_STANDBY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !power_q |=> state_q == acr_pkg::ACR_IDLE) else $error("converting in standby");
    AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        finish |=> done_q && result_q == $past(result_d)) else $error("done not set");
    AST_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == acr_pkg::ACR_IDLE && wr_ctl && bus.wdata[acr_pkg::BIT_START]
        && bus.wdata[acr_pkg::BIT_POWER]
        |=> start_q && sample_hold) else $error("start ignored");
    AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        finish |=> !start_q) else $error("start not cleared");
    AST_CHANNEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        channel_enable[chan_q] && $onehot(channel_enable)) else $error("bad channel");
    AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(done_q) && ien_q |-> irq) else $error("irq missing");
    AST_TIME: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_q == acr_pkg::ACR_CONVERT) && power_q && prs_q == 5'h01
        && !double_speed_clocking && !bus.wr |-> ##39 finish || !power_q) else $error("bad time");
    AST_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(bus.rd) && $past(bus.addr) == acr_pkg::ADDR_RESULT_HIGH
        |-> rd_data == $past(result_q[9:2])) else $error("high byte wrong");
    AST_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(bus.rd) && $past(bus.addr) == acr_pkg::ADDR_RESULT_LOW
        |-> rd_data == {6'h00, $past(result_q[1:0])}) else $error("low byte wrong");
    AST_DIV_X1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && !double_speed_clocking && prs_q == 5'h02 |-> div_q == 8'h07)
        else $error("single-speed divide wrong");
    AST_DIV_X1_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && !double_speed_clocking && prs_q == 5'h00 |-> div_q == 8'h7f)
        else $error("single-speed zero divide wrong");
    AST_DIV_X2: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && double_speed_clocking && prs_q == 5'h03 |-> div_q == 8'h05)
        else $error("double-speed divide wrong");
    AST_DIV_X2_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && double_speed_clocking && prs_q == 5'h00 |-> div_q == 8'h3f)
        else $error("double-speed zero divide wrong");
    AST_DONE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        done_q && !(wr_ctl && !bus.wdata[acr_pkg::BIT_DONE]) |=> done_q)
        else $error("done flag lost");
    AST_RESULT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !finish |=> $stable(result_q)) else $error("result changed outside completion");
    AST_SAMPLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sample_hold && tick |=> !sample_hold && dac_code == 10'h200)
        else $error("sample period wrong");
    AST_ABORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !power_q && state_q != acr_pkg::ACR_IDLE |=> !start_q && !cpu_halt)
        else $error("standby did not abort");
    AST_NO_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == acr_pkg::ACR_IDLE && wr_ctl && !bus.wdata[acr_pkg::BIT_POWER]
        |=> !start_q) else $error("start accepted without power");
endmodule // acr_adc_control

// ---- verif/acr_adc_control_tb.sv ----
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps

module acr_adc_control_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic sys_clk;
    logic rst_n;
    acr_pkg::acr_bus_s bus;
    logic [7:0] rd_data;
    logic double_speed_clocking;
    logic cmp_in;
    logic [9:0] vin;
    logic [7:0] channel_enable;
    logic [9:0] dac_code;
    logic sample_hold;
    logic converter_power_on;
    logic cpu_halt;
    logic irq;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    acr_adc_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .double_speed_clocking(double_speed_clocking), .cmp_in(cmp_in),
        .channel_enable(channel_enable), .dac_code(dac_code), .sample_hold(sample_hold),
        .converter_power_on(converter_power_on), .cpu_halt(cpu_halt), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Comparator model: high while the analog level is at or above the trial code.
    always @(posedge sys_clk) begin
        cmp_in <= vin >= dac_code;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        check({2'h0, rd_data}, {2'h0, exp});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(acr_pkg::ADDR_PRESCALER, 8'h00);
        rd(acr_pkg::ADDR_CONTROL, 8'h00);
        rd(acr_pkg::ADDR_RESULT_LOW, 8'h00);
        rd(acr_pkg::ADDR_RESULT_HIGH, 8'h00);
        rd(acr_pkg::ADDR_IRQ_ENABLE, 8'h00);
        rd(8'h77, 8'h00);
        check({2'h0, channel_enable}, 10'h001);
        $display("test reset done");
    endtask

    task automatic t_power_channel;
        wr(acr_pkg::ADDR_CONTROL, 8'h08);
        rd(acr_pkg::ADDR_CONTROL, 8'h00);
        check({9'h0, converter_power_on}, 10'h000);
        for (int n = 0; n < 8; n++) begin
            wr(acr_pkg::ADDR_CONTROL, 8'h20 | 8'(n));
            #1;
            check({2'h0, channel_enable}, 10'h001 << n);
            check({9'h0, converter_power_on}, 10'h001);
        end
        wr(acr_pkg::ADDR_PRESCALER, 8'h1f);
        rd(acr_pkg::ADDR_PRESCALER, 8'h1f);
        repeat (500) @(posedge sys_clk);
        $display("test power and channel done");
    endtask

    // One conversion; expected length is 11 converter periods of the chosen divider.
    task automatic conv(input logic [4:0] prs, input logic x2, input logic [9:0] v,
                        input logic halt);
        int div;
        int cnt;
        div = (prs == 5'h00) ? (x2 ? 64 : 128) : (x2 ? 2 : 4) * int'(prs);
        cnt = 0;
        @(posedge sys_clk);
        double_speed_clocking <= x2;
        vin <= v;
        wr(acr_pkg::ADDR_PRESCALER, {3'h0, prs});
        wr(acr_pkg::ADDR_CONTROL, {1'b0, halt, 6'h2d});
        while (irq !== 1'b1 && cnt < 3000) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            if (cnt == 1) check({9'h0, sample_hold}, 10'h001);
            if (cnt == 5) check({9'h0, cpu_halt}, {9'h0, halt});
        end
        check({9'h0, (cnt >= 11 * div - 1) && (cnt <= 11 * div + 2)}, 10'h001);
        check({9'h0, cpu_halt}, 10'h000);
        check(dac_code, v);
        rd(acr_pkg::ADDR_RESULT_HIGH, v[9:2]);
        rd(acr_pkg::ADDR_RESULT_LOW, {6'h00, v[1:0]});
        rd(acr_pkg::ADDR_CONTROL, {1'b0, halt, 6'h35});
        wr(acr_pkg::ADDR_CONTROL, 8'h25);
        #1;
        check({9'h0, irq}, 10'h000);
        $display("test conversion prs %h x2 %h done", prs, x2);
    endtask

    // Dropping the power bit mid-conversion abandons it and leaves the old result.
    task automatic t_abort;
        wr(acr_pkg::ADDR_PRESCALER, 8'h1f);
        wr(acr_pkg::ADDR_CONTROL, 8'h2d);
        repeat (10) @(posedge sys_clk);
        wr(acr_pkg::ADDR_CONTROL, 8'h05);
        rd(acr_pkg::ADDR_CONTROL, 8'h05);
        check({9'h0, irq}, 10'h000);
        rd(acr_pkg::ADDR_RESULT_HIGH, 8'h30);
        $display("test abort done");
    endtask

    // ****************************************
    // Main sequence and timeout
    // ****************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        double_speed_clocking = 1'b0;
        vin = 10'h000;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_power_channel();
        wr(acr_pkg::ADDR_IRQ_ENABLE, 8'h01);
        conv(5'h01, 1'b0, 10'h3ff, 1'b1);
        conv(5'h02, 1'b0, 10'h000, 1'b0);
        conv(5'h00, 1'b0, 10'h2a5, 1'b0);
        conv(5'h00, 1'b1, 10'h15a, 1'b0);
        conv(5'h03, 1'b1, 10'h0c3, 1'b1);
        t_abort();
        wrap_up();
    end
endmodule // acr_adc_control_tb
